/* core/msaf_top.sv */
// Mission status, alarm flags, start delay, first-sample stamp and sample count of the logger.
// Assumes commands, measurements and minute ticks arrive as one-cycle pulses on CLK.
`timescale 1ns/100ps
`include "msaf_consts.svh"
module msaf_top
   import msaf_pkg::*;
#(
   parameter int SENSOR_W = 8
) (
   input wire logic CLK, // Core clock, 250 MHz
   input wire logic ARST_N, // Asynchronous reset, battery power-on
   input wire logic [`MSAF_ADDR_W-1:0] REG_ADDR, // Register byte address
   input wire logic REG_RD, // Read strobe
   input wire logic REG_WR, // Write strobe
   input wire logic [7:0] REG_WDATA, // Write data
   output logic [7:0] REG_RDATA, // Read data, one cycle after strobe
   output logic REG_RVALID, // Read data valid pulse
   input wire logic CLEAR_MEM, // Clear-memory command pulse
   input wire logic START_MISSION, // Start-mission command pulse
   input wire logic STOP_MISSION, // Stop-mission command pulse
   input wire logic ALARM_TRIGGERED_START, // Start logging on temperature alarm
   input wire logic MINUTE_TICK, // One pulse per real-time-clock minute
   input wire logic [47:0] RTC_TIME, // Current BCD date and time
   input wire logic MEAS_VALID, // Wake-up measurement done pulse
   input wire logic MEAS_FORCED, // Measurement was a forced conversion
   input wire logic TEMP_PRESENT, // Temperature taken this wake-up
   input wire logic [SENSOR_W-1:0] TEMP_VALUE, // Temperature reading
   input wire logic HUM_PRESENT, // Humidity taken this wake-up
   input wire logic [SENSOR_W-1:0] HUM_VALUE, // Humidity reading
   input wire logic [SENSOR_W-1:0] TEMP_HIGH_LIMIT, // Temperature over threshold
   input wire logic [SENSOR_W-1:0] TEMP_LOW_LIMIT, // Temperature under threshold
   input wire logic [SENSOR_W-1:0] HUM_HIGH_LIMIT, // Humidity over threshold
   input wire logic [SENSOR_W-1:0] HUM_LOW_LIMIT, // Humidity under threshold
   input wire logic TEMPERATURE_OVER_ENABLE, // Temperature over alarm enable
   input wire logic TEMPERATURE_UNDER_ENABLE, // Temperature under alarm enable
   input wire logic HUMIDITY_OVER_ENABLE, // Humidity over alarm enable
   input wire logic HUMIDITY_UNDER_ENABLE, // Humidity under alarm enable
   output logic LOGGING_ACTIVE, // Mission in progress
   output logic AWAITING_TRIGGER_ALARM, // Waiting for start alarm
   output logic LOG_WIPED, // Memory cleared, ready to start
   output logic START_ACCEPTED, // Start command succeeded pulse
   output logic LOG_SAMPLE, // Store this wake-up to the log pulse
   output logic SAMPLING_ARMED // Wake-ups are checked or logged
);
   msaf_regs_t r;
   msaf_regs_t next_r;
   logic t_over;
   logic t_under;
   logic h_over;
   logic h_under;
   logic temp_alarm;
   logic mission_meas;
   logic forced_meas;
   logic flag_meas;
   logic [7:0] alarm_byte;
   logic [7:0] general_byte;
   logic [47:0] captured_time;
   logic [7:0] read_byte;
   logic clear_ok;
   logic start_accept;
   logic stop_ok;
   logic write_ok;

   msaf_cmp #(.W(SENSOR_W)) u_temp_cmp (
      .present(TEMP_PRESENT),
      .value(TEMP_VALUE),
      .high_limit(TEMP_HIGH_LIMIT),
      .low_limit(TEMP_LOW_LIMIT),
      .over_enable(TEMPERATURE_OVER_ENABLE),
      .under_enable(TEMPERATURE_UNDER_ENABLE),
      .over_hit(t_over),
      .under_hit(t_under)
   );

   msaf_cmp #(.W(SENSOR_W)) u_hum_cmp (
      .present(HUM_PRESENT),
      .value(HUM_VALUE),
      .high_limit(HUM_HIGH_LIMIT),
      .low_limit(HUM_LOW_LIMIT),
      .over_enable(HUMIDITY_OVER_ENABLE),
      .under_enable(HUMIDITY_UNDER_ENABLE),
      .over_hit(h_over),
      .under_hit(h_under)
   );

   // Zero positions of the stamp are forced so the stored bytes stay valid BCD fields.
   assign captured_time = RTC_TIME & `MSAF_STAMP_MASK;

   always_comb begin
      alarm_byte = `MSAF_ALARM_FIXED;
      alarm_byte[`MSAF_BIT_RESTART] = r.restart_flag;
      alarm_byte[`MSAF_BIT_HUM_OVER] = r.hum_over;
      alarm_byte[`MSAF_BIT_HUM_UNDER] = r.hum_under;
      alarm_byte[`MSAF_BIT_TEMP_OVER] = r.temp_over;
      alarm_byte[`MSAF_BIT_TEMP_UNDER] = r.temp_under;
      general_byte = `MSAF_GENERAL_FIXED;
      general_byte[`MSAF_BIT_AWAITING] = r.awaiting;
      general_byte[`MSAF_BIT_WIPED] = r.wiped;
      general_byte[`MSAF_BIT_ACTIVE] = r.active;
   end

   always_comb begin
      // Wake-ups during the delay are not measurements of the mission and are ignored.
      mission_meas = MEAS_VALID && !MEAS_FORCED && (r.state == MSAF_LOGGING);
      forced_meas = MEAS_VALID && MEAS_FORCED && !r.active;
      flag_meas = mission_meas || forced_meas;
      temp_alarm = MEAS_VALID && !MEAS_FORCED && (r.state == MSAF_WAIT_ALARM)
                   && (t_over || t_under);
   end

   always_comb begin
      // Clear is refused during a mission so that a running log is never lost.
      clear_ok = CLEAR_MEM && !r.active;
      // A start beside a clear is refused so the two never race over the cleared bit.
      start_accept = START_MISSION && r.wiped && !CLEAR_MEM && (r.state == MSAF_IDLE);
      stop_ok = STOP_MISSION && r.active;
      // Delay writes are locked while a mission runs and in the cycle of a start.
      write_ok = REG_WR && !r.active && !START_MISSION;
   end

   // One explicit item per byte keeps every select at a fixed width.
   always_comb begin
      read_byte = 8'h00;
      case (REG_ADDR)
         `MSAF_OFS_ALARM: begin
            read_byte = alarm_byte;
         end
         `MSAF_OFS_GENERAL: begin
            read_byte = general_byte;
         end
         `MSAF_OFS_DELAY0: begin
            read_byte = r.delay[7:0];
         end
         `MSAF_OFS_DELAY1: begin
            read_byte = r.delay[15:8];
         end
         `MSAF_OFS_DELAY2: begin
            read_byte = r.delay[23:16];
         end
         `MSAF_OFS_STAMP0: begin
            read_byte = r.stamp[7:0];
         end
         `MSAF_OFS_STAMP1: begin
            read_byte = r.stamp[15:8];
         end
         `MSAF_OFS_STAMP2: begin
            read_byte = r.stamp[23:16];
         end
         `MSAF_OFS_STAMP3: begin
            read_byte = r.stamp[31:24];
         end
         `MSAF_OFS_STAMP4: begin
            read_byte = r.stamp[39:32];
         end
         `MSAF_OFS_STAMP5: begin
            read_byte = r.stamp[47:40];
         end
         `MSAF_OFS_COUNT0: begin
            read_byte = r.count[7:0];
         end
         `MSAF_OFS_COUNT1: begin
            read_byte = r.count[15:8];
         end
         `MSAF_OFS_COUNT2: begin
            read_byte = r.count[23:16];
         end
         default: begin
            read_byte = 8'h00;
         end
      endcase
   end

   always_comb begin
      next_r = r;
      next_r.rvalid = 1'b0;
      next_r.log_strobe = 1'b0;
      next_r.start_ok = 1'b0;

      // Clear is evaluated first so that any flag event in the same cycle wins.
      if (clear_ok) begin
         next_r.restart_flag = 1'b0;
         next_r.hum_over = 1'b0;
         next_r.hum_under = 1'b0;
         next_r.temp_over = 1'b0;
         next_r.temp_under = 1'b0;
         next_r.stamp = `MSAF_RST_STAMP;
         next_r.count = `MSAF_RST_COUNT;
         next_r.wiped = 1'b1;
         // The awaiting bit is deliberately left alone here.
         next_r.awaiting = r.awaiting;
      end

      if (write_ok) begin
         case (REG_ADDR)
            `MSAF_OFS_DELAY0: begin
               next_r.delay[7:0] = REG_WDATA;
            end
            `MSAF_OFS_DELAY1: begin
               next_r.delay[15:8] = REG_WDATA;
            end
            `MSAF_OFS_DELAY2: begin
               next_r.delay[23:16] = REG_WDATA;
            end
            default: begin
               next_r.delay = next_r.delay;
            end
         endcase
      end

      if (flag_meas) begin
         if (h_over) begin
            next_r.hum_over = 1'b1;
         end
         if (h_under) begin
            next_r.hum_under = 1'b1;
         end
         if (t_over) begin
            next_r.temp_over = 1'b1;
         end
         if (t_under) begin
            next_r.temp_under = 1'b1;
         end
         if (t_over || t_under) begin
            next_r.awaiting = 1'b0;
         end
      end

      case (r.state)
         MSAF_IDLE: begin
            if (start_accept) begin
               next_r.wiped = 1'b0;
               next_r.active = 1'b1;
               next_r.start_ok = 1'b1;
               next_r.first_done = 1'b0;
               next_r.awaiting = ALARM_TRIGGERED_START;
               if (r.delay != `MSAF_RST_DELAY) begin
                  next_r.state = MSAF_DELAY;
               end else if (ALARM_TRIGGERED_START) begin
                  next_r.state = MSAF_WAIT_ALARM;
               end else begin
                  next_r.state = MSAF_LOGGING;
               end
            end
         end
         MSAF_DELAY: begin
            if (MINUTE_TICK) begin
               next_r.delay = r.delay - 24'h000001;
               if (r.delay == 24'h000001) begin
                  // The stored mode decides what follows the delay.
                  next_r.state = r.awaiting ? MSAF_WAIT_ALARM : MSAF_LOGGING;
               end
            end
         end
         MSAF_WAIT_ALARM: begin
            if (temp_alarm) begin
               next_r.state = MSAF_LOGGING;
               next_r.awaiting = 1'b0;
               next_r.temp_over = r.temp_over || t_over;
               next_r.temp_under = r.temp_under || t_under;
               next_r.log_strobe = 1'b1;
               next_r.first_done = 1'b1;
               next_r.stamp = captured_time;
               next_r.count = r.count;
            end
         end
         MSAF_LOGGING: begin
            if (mission_meas) begin
               next_r.log_strobe = 1'b1;
               // Both channels of one wake-up count once.
               next_r.count = r.count + 24'h000001;
               if (!r.first_done) begin
                  next_r.first_done = 1'b1;
                  next_r.stamp = captured_time;
               end
            end
         end
         default: begin
            next_r.state = MSAF_IDLE;
         end
      endcase

      // A stop ends the mission from any running state; awaiting stays as it was.
      if (stop_ok) begin
         next_r.state = MSAF_IDLE;
         next_r.active = 1'b0;
         next_r.log_strobe = 1'b0;
      end

      if (REG_RD) begin
         next_r.rvalid = 1'b1;
         next_r.rdata = read_byte;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r.state <= MSAF_IDLE;
         r.restart_flag <= `MSAF_RST_RESTART;
         r.hum_over <= 1'b0;
         r.hum_under <= 1'b0;
         r.temp_over <= 1'b0;
         r.temp_under <= 1'b0;
         r.awaiting <= 1'b0;
         r.wiped <= 1'b0;
         r.active <= 1'b0;
         r.first_done <= 1'b0;
         r.delay <= `MSAF_RST_DELAY;
         r.stamp <= `MSAF_RST_STAMP;
         r.count <= `MSAF_RST_COUNT;
         r.rdata <= 8'h00;
         r.rvalid <= 1'b0;
         r.log_strobe <= 1'b0;
         r.start_ok <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign REG_RDATA = r.rdata;
   assign REG_RVALID = r.rvalid;
   assign LOGGING_ACTIVE = r.active;
   assign AWAITING_TRIGGER_ALARM = r.awaiting;
   assign LOG_WIPED = r.wiped;
   assign START_ACCEPTED = r.start_ok;
   assign LOG_SAMPLE = r.log_strobe;
   assign SAMPLING_ARMED = (r.state == MSAF_WAIT_ALARM) || (r.state == MSAF_LOGGING);
endmodule

/* core/msaf_consts.svh */
// Register offsets, field positions, reset values and masks of the mission status block.
// Assumes byte-wide register access at the offsets below, and a host that drives the commands.
`ifndef MSAF_CONSTS_SVH
`define MSAF_CONSTS_SVH

`define MSAF_ADDR_W 10
`define MSAF_OFS_ALARM 10'h214
`define MSAF_OFS_GENERAL 10'h215
`define MSAF_OFS_DELAY0 10'h216
`define MSAF_OFS_DELAY1 10'h217
`define MSAF_OFS_DELAY2 10'h218
`define MSAF_OFS_STAMP0 10'h219
`define MSAF_OFS_STAMP1 10'h21A
`define MSAF_OFS_STAMP2 10'h21B
`define MSAF_OFS_STAMP3 10'h21C
`define MSAF_OFS_STAMP4 10'h21D
`define MSAF_OFS_STAMP5 10'h21E
`define MSAF_OFS_COUNT0 10'h220
`define MSAF_OFS_COUNT1 10'h221
`define MSAF_OFS_COUNT2 10'h222

`define MSAF_ALARM_FIXED 8'h70
`define MSAF_GENERAL_FIXED 8'hC0
`define MSAF_BIT_RESTART 7
`define MSAF_BIT_HUM_OVER 3
`define MSAF_BIT_HUM_UNDER 2
`define MSAF_BIT_TEMP_OVER 1
`define MSAF_BIT_TEMP_UNDER 0
`define MSAF_BIT_AWAITING 4
`define MSAF_BIT_WIPED 3
`define MSAF_BIT_ACTIVE 1

`define MSAF_RST_RESTART 1'h1
`define MSAF_RST_DELAY 24'h000000
`define MSAF_RST_COUNT 24'h000000
`define MSAF_RST_STAMP 48'h000000000000
// Bytes low to high: seconds, minutes, hours, date, month with century, year.
`define MSAF_STAMP_MASK 48'hFF_BF_3F_7F_7F_7F

`endif

/* core/msaf_pkg.sv */
// Types shared by the mission status block.
// Assumes the constants header is included by each module that needs offsets.
package msaf_pkg;

   typedef enum logic [3:0] {
      MSAF_IDLE = 4'h1,
      MSAF_DELAY = 4'h2,
      MSAF_WAIT_ALARM = 4'h4,
      MSAF_LOGGING = 4'h8
   } msaf_state_t;

   typedef struct packed {
      msaf_state_t state;
      logic restart_flag;
      logic hum_over;
      logic hum_under;
      logic temp_over;
      logic temp_under;
      logic awaiting;
      logic wiped;
      logic active;
      logic first_done;
      logic [23:0] delay;
      logic [47:0] stamp;
      logic [23:0] count;
      logic [7:0] rdata;
      logic rvalid;
      logic log_strobe;
      logic start_ok;
   } msaf_regs_t;

endpackage

/* core/msaf_cmp.sv */
// Threshold comparator for one sensor channel with separate over and under enables.
// Assumes readings and thresholds share one unsigned code, larger meaning hotter or wetter.
`timescale 1ns/100ps
module msaf_cmp #(
   parameter int W = 8
) (
   input wire logic present, // Reading of this channel is valid
   input wire logic [W-1:0] value, // Converted reading
   input wire logic [W-1:0] high_limit, // Over threshold
   input wire logic [W-1:0] low_limit, // Under threshold
   input wire logic over_enable, // Over alarm allowed
   input wire logic under_enable, // Under alarm allowed
   output logic over_hit, // Enabled reading at or above high
   output logic under_hit // Enabled reading at or below low
);
   always_comb begin
      over_hit = present && over_enable && (value >= high_limit);
      under_hit = present && under_enable && (value <= low_limit);
   end
endmodule

/* dv/msaf_assertions.sv */
// Concurrent checks on the mission status block, seeing its top-level ports only.
// Assumes one clock domain with the asynchronous active-low reset.
`timescale 1ns/100ps
`include "msaf_consts.svh"
module msaf_assertions (
   input wire logic CLK, // Core clock
   input wire logic ARST_N, // Asynchronous reset
   input wire logic [`MSAF_ADDR_W-1:0] REG_ADDR, // Register byte address
   input wire logic REG_RD, // Read strobe
   input wire logic [7:0] REG_RDATA, // Read data
   input wire logic REG_RVALID, // Read data valid
   input wire logic CLEAR_MEM, // Clear-memory pulse
   input wire logic START_MISSION, // Start pulse
   input wire logic STOP_MISSION, // Stop pulse
   input wire logic MEAS_VALID, // Measurement pulse
   input wire logic LOGGING_ACTIVE, // Mission in progress
   input wire logic AWAITING_TRIGGER_ALARM, // Waiting for start alarm
   input wire logic LOG_WIPED, // Memory cleared
   input wire logic START_ACCEPTED, // Start accepted pulse
   input wire logic LOG_SAMPLE, // Sample logged pulse
   input wire logic SAMPLING_ARMED // Wake-ups checked or logged
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   a_read_answer: assert property (REG_RD |=> REG_RVALID)
      else $error("read strobe got no answer");
   a_alarm_fixed: assert property ($past(REG_RD) && $past(REG_ADDR) == `MSAF_OFS_ALARM |->
      REG_RDATA[6:4] == 3'h7) else $error("alarm register fixed bits wrong");
   a_general_fixed: assert property ($past(REG_RD) && $past(REG_ADDR) == `MSAF_OFS_GENERAL
      |-> (REG_RDATA & 8'hE5) == 8'hC0) else $error("general register fixed bits wrong");
   a_start_wiped: assert property (START_ACCEPTED |-> $past(LOG_WIPED) && !LOG_WIPED)
      else $error("start accepted without cleared memory");
   a_start_pulse: assert property (START_ACCEPTED |-> LOGGING_ACTIVE ##1 !START_ACCEPTED)
      else $error("start pulse or active level wrong");
   a_clear_wipes: assert property (CLEAR_MEM && !LOGGING_ACTIVE |=> LOG_WIPED)
      else $error("clear did not set cleared bit");
   a_stop_ends: assert property (STOP_MISSION && !START_MISSION |=> !LOGGING_ACTIVE)
      else $error("mission still active after stop");
   a_await_keep: assert property (CLEAR_MEM && !MEAS_VALID |=> $stable(AWAITING_TRIGGER_ALARM))
      else $error("clear changed awaiting bit");
   a_armed_active: assert property (SAMPLING_ARMED |-> LOGGING_ACTIVE)
      else $error("armed outside a mission");
   a_log_cause: assert property (LOG_SAMPLE |-> $past(MEAS_VALID) && $past(SAMPLING_ARMED))
      else $error("sample logged without armed measurement");
endmodule

bind msaf_top msaf_assertions u_msaf_assertions (.CLK, .ARST_N, .REG_ADDR, .REG_RD, .REG_RDATA,
   .REG_RVALID, .CLEAR_MEM, .START_MISSION, .STOP_MISSION, .MEAS_VALID, .LOGGING_ACTIVE,
   .AWAITING_TRIGGER_ALARM, .LOG_WIPED, .START_ACCEPTED, .LOG_SAMPLE, .SAMPLING_ARMED);

/* dv/msaf_host.sv */
// Host master model driving the byte register port of the mission status block.
// Assumes a strobe taken at a rising edge and a read answer one cycle later.
`timescale 1ns/100ps
module msaf_host (
   input wire logic CLK, // Core clock
   input wire logic [7:0] REG_RDATA, // Read data
   input wire logic REG_RVALID, // Read answer pulse
   output logic [9:0] REG_ADDR, // Byte address
   output logic REG_RD, // Read strobe
   output logic REG_WR, // Write strobe
   output logic [7:0] REG_WDATA // Write data
);
   initial begin
      REG_ADDR = 10'h000;
      REG_RD = 1'h0;
      REG_WR = 1'h0;
      REG_WDATA = 8'h00;
   end

   // Released lines show the inverse of their last value so stale data never looks valid.
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge CLK);
      #1;
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'h1;
      @(posedge CLK);
      #1;
      REG_WR = 1'h0;
      REG_ADDR = ~a;
      REG_WDATA = ~d;
   endtask

   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge CLK);
      #1;
      REG_ADDR = a;
      REG_RD = 1'h1;
      @(posedge CLK);
      #1;
      REG_RD = 1'h0;
      REG_ADDR = ~a;
      d = REG_RVALID ? REG_RDATA : 8'hXX;
   endtask
endmodule

/* dv/msaf_top_tb.sv */
// Self-checking bench for the mission status block with a register host model.
// Assumes the 250 MHz clock and one-cycle command and measurement pulses.
`timescale 1ns/100ps
`include "msaf_consts.svh"
module msaf_top_tb;
   logic clk = 1'h0, arst_n = 1'h0, clear_mem = 1'h0, start = 1'h0, stop = 1'h0;
   logic sut = 1'h0, tick = 1'h0, mvalid = 1'h0, forced = 1'h0, t_pres = 1'h0, h_pres = 1'h0;
   logic reg_rd, reg_wr, rvalid, active, awaiting, wiped, accepted, logged, armed;
   logic [9:0] reg_addr;
   logic [7:0] wdata, rdata, got, t_val = 8'h00, h_val = 8'h00;
   logic [7:0] t_hi = 8'h80, t_lo = 8'h20, h_hi = 8'hC0, h_lo = 8'h10;
   logic [3:0] en = 4'hF;
   logic [47:0] rtc = 48'h25_12_31_23_59_58;
   int fail_count = 0, n_compared = 0;

   always #2 clk = ~clk;

   msaf_top u_msaf_top (.CLK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_RD(reg_rd),
      .REG_WR(reg_wr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .CLEAR_MEM(clear_mem), .START_MISSION(start), .STOP_MISSION(stop),
      .ALARM_TRIGGERED_START(sut), .MINUTE_TICK(tick), .RTC_TIME(rtc), .MEAS_VALID(mvalid),
      .MEAS_FORCED(forced), .TEMP_PRESENT(t_pres), .TEMP_VALUE(t_val), .HUM_PRESENT(h_pres),
      .HUM_VALUE(h_val), .TEMP_HIGH_LIMIT(t_hi), .TEMP_LOW_LIMIT(t_lo), .HUM_HIGH_LIMIT(h_hi),
      .HUM_LOW_LIMIT(h_lo), .TEMPERATURE_OVER_ENABLE(en[3]), .TEMPERATURE_UNDER_ENABLE(en[2]),
      .HUMIDITY_OVER_ENABLE(en[1]), .HUMIDITY_UNDER_ENABLE(en[0]), .LOGGING_ACTIVE(active),
      .AWAITING_TRIGGER_ALARM(awaiting), .LOG_WIPED(wiped), .START_ACCEPTED(accepted),
      .LOG_SAMPLE(logged), .SAMPLING_ARMED(armed));
   msaf_host u_msaf_host (.CLK(clk), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_ADDR(reg_addr),
      .REG_RD(reg_rd), .REG_WR(reg_wr), .REG_WDATA(wdata));

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
      u_msaf_host.rd(a, got);
      chk(got, e);
   endtask

   // Order of the bits is clear, start, stop.
   task automatic cmd(input logic [2:0] c);
      @(posedge clk);
      #1;
      {clear_mem, start, stop} = c;
      @(posedge clk);
      #1;
      {clear_mem, start, stop} = 3'h0;
   endtask

   task automatic minute;
      @(posedge clk);
      #1;
      tick = 1'h1;
      @(posedge clk);
      #1;
      tick = 1'h0;
   endtask

   task automatic meas(input logic f, tp, hp, input logic [7:0] tv, hv);
      @(posedge clk);
      #1;
      {mvalid, forced, t_pres, h_pres} = {1'h1, f, tp, hp};
      t_val = tv;
      h_val = hv;
      @(posedge clk);
      #1;
      mvalid = 1'h0;
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic t_reset;
      rd_chk(`MSAF_OFS_ALARM, 8'hF0);
      rd_chk(`MSAF_OFS_GENERAL, 8'hC0);
      $display("test reset done");
   endtask

   task automatic t_mission;
      u_msaf_host.wr(`MSAF_OFS_ALARM, 8'h0F);
      rd_chk(`MSAF_OFS_ALARM, 8'hF0);
      cmd(3'h4);
      chk({7'h00, wiped}, 8'h01);
      rd_chk(`MSAF_OFS_ALARM, 8'h70);
      rd_chk(`MSAF_OFS_GENERAL, 8'hC8);
      u_msaf_host.wr(`MSAF_OFS_DELAY0, 8'h02);
      cmd(3'h2);
      chk({7'h00, accepted}, 8'h01);
      chk({7'h00, active}, 8'h01);
      rd_chk(`MSAF_OFS_GENERAL, 8'hC2);
      u_msaf_host.wr(`MSAF_OFS_DELAY0, 8'h09);
      rd_chk(`MSAF_OFS_DELAY0, 8'h02);
      meas(1'h0, 1'h1, 1'h0, 8'h90, 8'h00);
      chk({7'h00, logged}, 8'h00);
      rd_chk(`MSAF_OFS_ALARM, 8'h70);
      minute;
      rd_chk(`MSAF_OFS_DELAY0, 8'h01);
      minute;
      chk({7'h00, armed}, 8'h01);
      en = 4'hE;
      meas(1'h0, 1'h1, 1'h1, t_hi, h_lo);
      chk({7'h00, logged}, 8'h01);
      rd_chk(`MSAF_OFS_ALARM, 8'h72);
      meas(1'h0, 1'h1, 1'h0, t_lo, 8'h00);
      rd_chk(`MSAF_OFS_ALARM, 8'h73);
      rd_chk(`MSAF_OFS_COUNT0, 8'h02);
      rd_chk(`MSAF_OFS_STAMP0, 8'h58);
      rd_chk(`MSAF_OFS_STAMP5, 8'h25);
      cmd(3'h1);
      rd_chk(`MSAF_OFS_GENERAL, 8'hC0);
      $display("test mission done");
   endtask

   task automatic t_alarm;
      cmd(3'h4);
      sut = 1'h1;
      cmd(3'h2);
      rd_chk(`MSAF_OFS_GENERAL, 8'hD2);
      meas(1'h0, 1'h1, 1'h0, 8'h50, 8'h00);
      chk({7'h00, logged}, 8'h00);
      meas(1'h0, 1'h1, 1'h0, t_lo, 8'h00);
      chk({7'h00, logged}, 8'h01);
      rd_chk(`MSAF_OFS_GENERAL, 8'hC2);
      rd_chk(`MSAF_OFS_ALARM, 8'h71);
      rd_chk(`MSAF_OFS_COUNT0, 8'h00);
      cmd(3'h1);
      cmd(3'h2);
      chk({7'h00, accepted}, 8'h00);
      $display("test alarm start done");
   endtask

   task automatic t_stale;
      cmd(3'h4);
      cmd(3'h2);
      cmd(3'h1);
      rd_chk(`MSAF_OFS_GENERAL, 8'hD0);
      cmd(3'h4);
      rd_chk(`MSAF_OFS_GENERAL, 8'hD8);
      chk({7'h00, awaiting}, 8'h01);
      // The host lowers the over threshold to the bottom code before a forced conversion.
      t_hi = 8'h00;
      meas(1'h1, 1'h1, 1'h1, 8'h30, h_hi);
      chk({7'h00, logged}, 8'h00);
      rd_chk(`MSAF_OFS_GENERAL, 8'hC8);
      rd_chk(`MSAF_OFS_ALARM, 8'h7A);
      $display("test stale awaiting done");
   endtask

   initial begin
      #100000;
      fail_count++;
      stop_test;
   end

   initial begin
      repeat (12) @(posedge clk);
      #1;
      arst_n = 1'h1;
      t_reset;
      t_mission;
      t_alarm;
      t_stale;
      stop_test;
   end
endmodule
